// ---- bench/gdbp_port_asserts.sv ----
/* Checker for the GPIO data bank port, watching its ports only.
   Bound to gdbp_port from the testbench top. */
`timescale 1ns/100ps
module gdbp_port_asserts (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [47:0] pin_in,
    input wire logic [47:0] alt_out,
    input wire logic [47:0] alt_oe,
    input wire logic [47:0] pin_out,
    input wire logic [47:0] pin_oe,
    input wire logic [47:0] either_edge_capable
);
    // ==========================================================
    // Properties
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    logic c24;
    assign c24 = reg_wr && reg_addr == 8'h3B;
    AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_EE_MASK: assert property ($past(rst_n) |-> either_edge_capable == 48'h0300_0A00_0600)
        else $error("either edge mask wrong");
    AST_RSV_RD: assert property (reg_rd && reg_addr == 8'h4E |=> reg_rdata[7:4] == 4'h0)
        else $error("reserved bits not zero");
    AST_UNMAP: assert property (reg_rd && reg_addr == 8'h51 |=> reg_rdata == 8'h00)
        else $error("unmapped offset read nonzero");
    AST_OE_RSV: assert property ((pin_oe & ~48'h03FF_0FFF_F7FF) == 48'h0)
        else $error("reserved slot driven");
    // Reset itself is watched here, so the default disable is overridden
    AST_RST_OUT: assert property (disable iff (1'b0) !rst_n |=> pin_oe == 48'h0 && reg_rdata == 8'h00)
        else $error("outputs active in reset");
    AST_DIR: assert property (c24 && reg_wdata[7:2] == 6'h0 ##1 !c24 |=> pin_oe[24] == !$past(reg_wdata[0], 2))
        else $error("direction not applied");
    AST_OD: assert property (c24 && reg_wdata[7] && reg_wdata[3:2] == 2'h0 ##1 !c24 |=> !pin_out[24])
        else $error("open drain drove high");
    // Push-pull only: an open-drain pin releases its enable while the value is high
    AST_ALT: assert property (c24 && reg_wdata[3:2] != 2'h0 && !reg_wdata[7] ##1 !c24 |=>
        pin_oe[24] == $past(alt_oe[24]))
        else $error("alternate enable not passed");
endmodule

// ---- bench/testbench.sv ----
/* Self-checking bench for the GPIO data bank port.
   Drives every input itself; no far-side model. */
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected at %0t: %h %h", $time, a, b); end end
module testbench;
    logic ref_clk = 1'b0, rst_n = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
    logic [47:0] pin_in = '0, alt_out = '0, alt_oe = '0, pin_out, pin_oe, either_edge_capable;
    logic [47:0] dout_m = 48'h0008_002C_0000, dat_m = '0, pol_m = '0;
    localparam logic [47:0] ALT = 48'h0030_0000;
    int error_cnt = 0, total_checks = 0;
    always #5 ref_clk = ~ref_clk;
    gdbp_port i_dut (.ref_clk, .rst_n, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
        .pin_in, .alt_out, .alt_oe, .pin_out, .pin_oe, .either_edge_capable);
    // ==========================================================
    // Helpers
    function automatic logic [47:0] r48();
        r48 = 48'({$urandom, $urandom});
    endfunction
    // Input bits never keep written data, so the model only stores output slots
    function automatic logic [7:0] exp_bank(input int b);
        logic [47:0] m;
        m = ((dout_m & dat_m) | (~dout_m & (pin_in ^ pol_m))) & 48'h03FF_0FFF_F7FF;
        exp_bank = b < 6 ? m[8*b +: 8] : 8'h00;
    endfunction
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wb(input int b, input logic [7:0] v);
        acc(1'b1, 8'h4B + 8'(b), v);
        for (int i = 0; i < 8 && b < 6; i++)
            if (dout_m[8*b+i]) dat_m[8*b+i] = v[i];
    endtask
    task automatic chk_pins();
        logic [47:0] m;
        m = dout_m | ALT;
        @(posedge ref_clk);
        #1 `CHK(pin_oe, (dout_m & ~ALT) | (alt_oe & ALT))
        `CHK(pin_out & m, (dat_m & dout_m & ~ALT) | (alt_out & ALT))
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial
    begin
        logic [7:0] ra [5] = '{8'h3B, 8'h35, 8'h37, 8'h38, 8'h42};
        logic [7:0] rv [5] = '{8'h01, 8'h00, 8'h05, 8'h04, 8'h00};
        int b;
        void'($urandom(32'h61056DE4));
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (ra[i])
        begin
            acc(1'b0, ra[i], 8'h00);
            `CHK(d, rv[i])
        end
        `CHK(either_edge_capable, 48'h0300_0A00_0600)
        acc(1'b1, 8'h3B, 8'h00);
        acc(1'b1, 8'h3C, 8'h03);
        dout_m[24] = 1'b1;
        pol_m[25] = 1'b1;
        wb(3, 8'hFF);
        repeat (40)
        begin
            b = $urandom_range(6);
            @(posedge ref_clk);
            pin_in <= r48();
            alt_out <= r48();
            alt_oe <= r48();
            wb(b, 8'($urandom));
            acc(1'b0, 8'h4B + 8'(b), 8'h00);
            `CHK(d, exp_bank(b))
            chk_pins();
        end
        acc(1'b1, 8'h3B, 8'h80);
        wb(3, 8'h00);
        @(posedge ref_clk);
        #1 `CHK(({pin_oe[24], pin_out[24]}), 2'b10)
        wb(3, 8'h01);
        @(posedge ref_clk);
        #1 `CHK(pin_oe[24], 1'b0)
        acc(1'b1, 8'h3B, 8'h04);
        repeat (3) @(posedge ref_clk);
        close_out();
    end
    initial
    begin
        #100000;
        error_cnt++;
        close_out();
    end
endmodule
bind gdbp_port gdbp_port_asserts i_chk (.ref_clk, .rst_n, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata, .pin_in, .alt_out, .alt_oe, .pin_out, .pin_oe, .either_edge_capable);

// ---- design/gdbp_pin_cell.sv ----
/*
 * One GPIO pin: its data bit, its configuration byte and its pad drive.
 * Assumes register strobes last one cycle and the pad input is already
 * synchronous to ref_clk.
 */
`timescale 1ns/100ps
module gdbp_pin_cell
    import gdbp_pkg::*;
#(
    parameter logic VALID = 1'b1,
    parameter logic [7:0] CFG_RST = 8'h01
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic data_hit,
    input wire logic cfg_hit,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic wdata_bit,
    input wire logic [7:0] wdata,
    input wire logic pin_in,
    input wire logic alt_out,
    input wire logic alt_oe,
    output logic data_rd,
    output logic [7:0] cfg_rd,
    output logic pin_out,
    output logic pin_oe
);

    logic [7:0] cfg_q, cfg_d;
    logic data_q, data_d;
    logic out_q, out_d, oe_q, oe_d;
    logic is_in, pol, alt, val, drv;

    // ==========================================================
    // Next state
    always_comb
    begin
        is_in = cfg_q[CFG_DIR_BIT];
        pol = cfg_q[CFG_POL_BIT];
        alt = |cfg_q[CFG_FSEL_HI:CFG_FSEL_LO];
        cfg_d = cfg_q;
        data_d = data_q;
        if (VALID && cfg_hit && reg_wr)
        begin
            cfg_d = wdata;
        end
        if (VALID && data_hit && (reg_rd || reg_wr))
        begin
            if (is_in)
                data_d = pin_in ^ pol;
            else if (reg_wr)
                data_d = wdata_bit;
        end
        // Alternate function owns the pad when bits 3:2 are non-zero
        val = alt ? (alt_out ^ pol) : (data_q ^ pol);
        drv = alt ? alt_oe : ~is_in;
        out_d = VALID && !cfg_q[CFG_OD_BIT] && val;
        oe_d = VALID && drv && (!cfg_q[CFG_OD_BIT] || !val);
        // Input reads show the pin as seen in this cycle, same as what is latched
        data_rd = VALID && (is_in ? (pin_in ^ pol) : data_q);
        cfg_rd = VALID ? cfg_q : 8'h00;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cfg_q <= CFG_RST;
            data_q <= DATA_RESET;
            out_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            data_q <= data_d;
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    assign pin_out = out_q;
    assign pin_oe = oe_q;

endmodule

// ---- design/gdbp_pkg.sv ----
/*
 * Constants shared by the GPIO data bank port: register offsets inside the
 * power event runtime block, configuration field positions, reset values and
 * the slot map that ties bank and bit to a pin.
 * Assumes offsets are byte offsets relative to the block base, decoded upstream.
 */
package gdbp_pkg;

    // ==========================================================
    // Geometry
    localparam int BANKS = 6;
    localparam int SLOTS = 48;

    // ==========================================================
    // Data bank offsets
    localparam logic [7:0] OFF_DATA_BANK1 = 8'h4B;
    localparam logic [7:0] OFF_DATA_BANK2 = 8'h4C;
    localparam logic [7:0] OFF_DATA_BANK3 = 8'h4D;
    localparam logic [7:0] OFF_DATA_BANK4 = 8'h4E;
    localparam logic [7:0] OFF_DATA_BANK5 = 8'h4F;
    localparam logic [7:0] OFF_DATA_BANK6 = 8'h50;

    // ==========================================================
    // First configuration offset of each bank; slot i of a bank is base + bit
    localparam logic [7:0] OFF_CFG_BANK1 = 8'h23;
    localparam logic [7:0] OFF_CFG_BANK2 = 8'h2B;
    localparam logic [7:0] OFF_CFG_BANK3 = 8'h33;
    localparam logic [7:0] OFF_CFG_BANK4 = 8'h3B;
    localparam logic [7:0] OFF_CFG_BANK5 = 8'h3F;
    localparam logic [7:0] OFF_CFG_BANK6 = 8'h47;

    // ==========================================================
    // Configuration fields
    localparam int CFG_DIR_BIT = 0;
    localparam int CFG_POL_BIT = 1;
    localparam int CFG_FSEL_LO = 2;
    localparam int CFG_FSEL_HI = 3;
    localparam int CFG_OD_BIT = 7;
    localparam logic [7:0] CFG_RESET_INPUT = 8'h01;
    localparam logic [7:0] CFG_RESET_OUT_LOW = 8'h00;
    localparam logic [7:0] CFG_RESET_ALT1_IN = 8'h05;
    localparam logic [7:0] CFG_RESET_ALT1_OUT = 8'h04;
    localparam logic DATA_RESET = 1'b0;

    // ==========================================================
    // Slot map (slot = 8 * bank_index + bit)
    localparam logic [47:0] SLOT_VALID = 48'h03FF_0FFF_F7FF;
    // Either-edge capable slots: 9, 10, 25, 27, 40 and 41
    localparam logic [47:0] SLOT_EITHER_EDGE = 48'h0300_0A00_0600;
    localparam int SLOT_DRIVE_DENSITY0 = 24;
    localparam int SLOT_DRIVE_DENSITY1 = 25;
    localparam int SLOT_SERIAL2_FIRST = 32;
    localparam int SLOT_SERIAL2_TXD = 35;
    localparam int SLOT_FAN_CTRL2 = 18;
    localparam int SLOT_FAN_CTRL1 = 19;
    localparam int SLOT_IR_RX = 20;
    localparam int SLOT_IR_TX = 21;

    function automatic logic [7:0] gdbp_data_off(input int bank);
        case (bank)
            0: gdbp_data_off = OFF_DATA_BANK1;
            1: gdbp_data_off = OFF_DATA_BANK2;
            2: gdbp_data_off = OFF_DATA_BANK3;
            3: gdbp_data_off = OFF_DATA_BANK4;
            4: gdbp_data_off = OFF_DATA_BANK5;
            default: gdbp_data_off = OFF_DATA_BANK6;
        endcase
    endfunction

    function automatic logic [7:0] gdbp_cfg_off(input int slot);
        logic [7:0] base;
        case (slot / 8)
            0: base = OFF_CFG_BANK1;
            1: base = OFF_CFG_BANK2;
            2: base = OFF_CFG_BANK3;
            3: base = OFF_CFG_BANK4;
            4: base = OFF_CFG_BANK5;
            default: base = OFF_CFG_BANK6;
        endcase
        gdbp_cfg_off = base + 8'(slot % 8);
    endfunction

    function automatic logic [7:0] gdbp_cfg_reset(input int slot);
        case (slot)
            SLOT_FAN_CTRL2, SLOT_FAN_CTRL1, SLOT_SERIAL2_TXD: gdbp_cfg_reset = CFG_RESET_OUT_LOW;
            SLOT_IR_RX: gdbp_cfg_reset = CFG_RESET_ALT1_IN;
            SLOT_IR_TX: gdbp_cfg_reset = CFG_RESET_ALT1_OUT;
            default: gdbp_cfg_reset = CFG_RESET_INPUT;
        endcase
    endfunction

endpackage

// ---- design/gdbp_port.sv ----
/*
 * GPIO data bank port: six data bank registers and one configuration byte per
 * pin, reached through the byte register port of the power event runtime block.
 * Assumes reg_addr is already the offset from the block base and that reg_rd and
 * reg_wr are one-cycle strobes. Alternate function logic sits outside.
 */
//
// Function
// - Every pin has one data bit and its own eight-bit configuration register.
// - Data bits are packed into six eight-bit banks, one bit position per pin.
// - Reading the data bit of an input pin returns the pin's present level.
// - An output pin is driven with the value software wrote to its data bit.
// - An input pin's data bit is latched on every read and write of its bank; an output pin's only on writes.
// - Registers decode as offsets from the runtime block base, banks at 4B to 50 hex.
// - Bank four bit 1 is the drive density select 1 pin, also either-edge capable.
// - Bank five bits 0 to 7 are serial port 2 modem lines, bit 3 being transmit data.
// - Bank four bit 0 at offset 4E hex is the drive density select 0 pin.
// - Config bit 0 sets direction, bit 1 polarity, bit 7 open drain versus push-pull.
// - Config bits 3 and 2 choose between the default and alternate functions.
// - Writing the data bit of an input pin changes neither pin nor read value.
// - Reading the data bit of an output pin returns the last value written.
`timescale 1ns/100ps
module gdbp_port
    import gdbp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [47:0] pin_in,
    input wire logic [47:0] alt_out,
    input wire logic [47:0] alt_oe,
    output logic [47:0] pin_out,
    output logic [47:0] pin_oe,
    output logic [47:0] either_edge_capable
)
;

    logic [47:0] data_rd;
    logic [7:0] cfg_rd [SLOTS];
    logic [BANKS-1:0] bank_hit;
    logic [47:0] cfg_hit;
    logic [7:0] rdata_q, rdata_d;
    logic [47:0] ee_q;

    // ==========================================================
    // Pin cells
    genvar gs;
    generate
        for (gs = 0; gs < SLOTS; gs++)
        begin : g_slot
            // Reserved positions get an inert cell, so they read zero and ignore writes
            gdbp_pin_cell #(
                .VALID(SLOT_VALID[gs]),
                .CFG_RST(gdbp_cfg_reset(gs))
            ) u_cell (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .data_hit(bank_hit[gs / 8]),
                .cfg_hit(cfg_hit[gs]),
                .reg_rd(reg_rd),
                .reg_wr(reg_wr),
                .wdata_bit(reg_wdata[gs % 8]),
                .wdata(reg_wdata),
                .pin_in(pin_in[gs]),
                .alt_out(alt_out[gs]),
                .alt_oe(alt_oe[gs]),
                .data_rd(data_rd[gs]),
                .cfg_rd(cfg_rd[gs]),
                .pin_out(pin_out[gs]),
                .pin_oe(pin_oe[gs])
            );
            assign cfg_hit[gs] = SLOT_VALID[gs] && (reg_addr == gdbp_cfg_off(gs));
        end
        for (gs = 0; gs < BANKS; gs++)
        begin : g_bank
            // Bank 4 sits at 4E: bit 0 drive density 0, bit 1 drive density 1
            // Bank 5 carries serial port 2 modem lines, transmit data on bit 3
            assign bank_hit[gs] = reg_addr == gdbp_data_off(gs);
        end
    endgenerate

    // ==========================================================
    // Read data, registered one cycle after the strobe
    always_comb
    begin
        rdata_d = rdata_q;
        if (reg_rd)
        begin
            rdata_d = 8'h00;
            for (int b = 0; b < BANKS; b++)
            begin
                if (bank_hit[b])
                    rdata_d = data_rd[b * 8 +: 8];
            end
            for (int s = 0; s < SLOTS; s++)
            begin
                if (cfg_hit[s])
                    rdata_d = cfg_rd[s];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rdata_q <= 8'h00;
            ee_q <= 48'h0000_0000_0000;
        end
        else
        begin
            rdata_q <= rdata_d;
            ee_q <= SLOT_EITHER_EDGE;
        end
    end

    assign reg_rdata = rdata_q;
    assign either_edge_capable = ee_q;

endmodule
